// File: design/cvtcfg_defs.svh
`ifndef CVTCFG_DEFS_SVH
`define CVTCFG_DEFS_SVH

// ****************************************
// Register command codes
// ****************************************
`define CVTCFG_CMD_DELAY 8'hD1
`define CVTCFG_CMD_OVERRIDE 8'hD2
`define CVTCFG_CMD_LOOP 8'hD3

// ****************************************
// Field positions
// ****************************************
`define CVTCFG_PGD_MSB 5
`define CVTCFG_PGD_LSB 3
`define CVTCFG_POD_MSB 2
`define CVTCFG_POD_LSB 0
`define CVTCFG_TRK_BIT 7
`define CVTCFG_SEQ_BIT 6
`define CVTCFG_FSKIP_BIT 4
`define CVTCFG_SST_MSB 3
`define CVTCFG_SST_LSB 2
`define CVTCFG_UVL_BIT 1
`define CVTCFG_CM_BIT 0
`define CVTCFG_RINJ_BIT 7
`define CVTCFG_RRS_MSB 5
`define CVTCFG_RRS_LSB 4
`define CVTCFG_FS_MSB 2
`define CVTCFG_FS_LSB 0

// ****************************************
// Reset values
// ****************************************
`define CVTCFG_PGD_RESET 3'h0
`define CVTCFG_POD_RESET 3'h2
`define CVTCFG_FSKIP_RESET 1'h1
`define CVTCFG_FS_RESET 3'h3

// ****************************************
// Timing
// ****************************************
`define CVTCFG_CLK_PERIOD_NS 5
`define CVTCFG_TICK_NS 1000
`define CVTCFG_TICK_CYCLES \
  ((`CVTCFG_TICK_NS + `CVTCFG_CLK_PERIOD_NS - 1) / `CVTCFG_CLK_PERIOD_NS)
`define CVTCFG_BASE_DELAY_US 256
`define CVTCFG_PGD_LONG_US 131072
`define CVTCFG_SETTLE_CYCLES 3'h4

`endif

// File: design/cvtcfg_pkg.sv
package cvtcfg_pkg;
  // Three-bit delay or frequency code.
  typedef logic [2:0] cvtcfg_code3_t;
  // Microsecond count wide enough for the longest delay.
  typedef logic [17:0] cvtcfg_us_t;
  // Strap load sequence, Gray coded along its path.
  typedef enum logic [1:0] {
    CVTCFG_SETTLE = 2'b00,
    CVTCFG_LOAD = 2'b01,
    CVTCFG_RUN = 2'b11
  } cvtcfg_load_e;
endpackage

// File: design/cvtcfg_delay_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "cvtcfg_defs.svh"

module cvtcfg_delay_timer #(
  parameter bit LONG_TOP = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Time base and control
  input wire logic us_tick,
  input wire logic arm,
  input wire cvtcfg_pkg::cvtcfg_code3_t code,
  // Result
  output logic done
);
  import cvtcfg_pkg::*;

  cvtcfg_us_t elapsed;
  cvtcfg_us_t terminal;

  // Delay in microseconds for a code; doubles per step from the base, except code 7 when long_top is set.
  function automatic cvtcfg_us_t delay_us(input cvtcfg_code3_t c,
                                          input bit long_top);
    cvtcfg_us_t base;
    base = cvtcfg_us_t'(`CVTCFG_BASE_DELAY_US);
    if (long_top && c == 3'h7) begin
      delay_us = cvtcfg_us_t'(`CVTCFG_PGD_LONG_US);
    end else begin
      delay_us = base << c;
    end
  endfunction

  assign terminal = delay_us(code, LONG_TOP);

  // Count microsecond ticks while armed; the count saturates so that a
  // later change of code to a shorter delay still ends it at once.
  always_ff @(posedge ref_clk) begin
    if (reset || !arm) begin
      elapsed <= '0;
    end else if (us_tick && elapsed < terminal) begin
      elapsed <= elapsed + 18'h00001;
    end
  end

  // Done rises once the selected delay has fully elapsed.
  always_ff @(posedge ref_clk) begin
    if (reset || !arm) begin
      done <= 1'b0;
    end else begin
      done <= (elapsed >= terminal);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_done_count;
    done |-> $past(elapsed) >= $past(terminal) && $past(arm);
  endproperty
  a_done_count: assert property (p_done_count)
    else $error("delay done before terminal count");
endmodule

`default_nettype wire

// File: design/cvtcfg_override_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "cvtcfg_defs.svh"

// Overview of operation
// - Power-good delay 256us doubling, 111 is 131ms
// - Power-on delay 256us doubling to 32.768ms
// - Strap fields load, read back, writable
// - Writes last until next power-on reset
// - Override bit 7 selects external tracking
// - Override bit 6 selects external ramp sequencing
// - Bit 4 forces skip during soft start
// - Bits 3:2 soft-start 1, 2, 4, 8 ms
// - Bit 1 undervoltage hiccup or latch-off
// - Bit 0 skip or forced continuous conduction
// - Loop bit 7 enables ramp injection
// - Bits 5:4 scale ramp resistor
// - Frequency bits 2:0 reset 011, writable
// - Frequency code table up to 1.225 MHz
// - Delay register: good 5:3, on 2:0
module cvtcfg_override_regs #(
  parameter int TICK_CYCLES = `CVTCFG_TICK_CYCLES
) (
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register command port
  input wire logic [7:0] cmd_code,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic rd_ack,
  output logic cmd_nack,
  // Pin straps
  input wire logic strap_tracking,
  input wire logic strap_ramp,
  input wire logic [1:0] strap_soft_start,
  input wire logic strap_uv_latch,
  input wire logic strap_conduction,
  input wire logic strap_ramp_injection,
  input wire logic [1:0] strap_ramp_resistor,
  // Converter status from the analog side
  input wire logic softstart_active,
  input wire logic power_on_request,
  input wire logic power_good_request,
  // Configuration to the analog side
  output logic external_tracking_select,
  output logic external_ramp_select,
  output logic force_skip_during_softstart,
  output logic [1:0] soft_start_time_code,
  output logic undervoltage_latch_select,
  output logic conduction_mode_select,
  output logic forced_continuous_conduction,
  output logic ramp_injection_enable,
  output logic [1:0] ramp_resistor_scale,
  output cvtcfg_pkg::cvtcfg_code3_t switching_frequency_code,
  output cvtcfg_pkg::cvtcfg_code3_t power_good_delay_code,
  output cvtcfg_pkg::cvtcfg_code3_t power_on_delay_code,
  // Sequencing results
  output logic config_ready,
  output logic power_on_delay_done,
  output logic power_good_output
);
  import cvtcfg_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] pin_f;

  assign pin_raw = {power_good_request, power_on_request, softstart_active,
                    strap_ramp_resistor, strap_ramp_injection,
                    strap_conduction, strap_uv_latch, strap_soft_start,
                    strap_ramp, strap_tracking};

  // Three stages; a change is taken only once the last two agree.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_f <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_f <= (sync2 & sync3) | (pin_f & (sync2 ^ sync3));
    end
  end

  // ****************************************
  // Strap load sequence
  // ****************************************
  cvtcfg_load_e state;
  cvtcfg_load_e next_state;
  logic [2:0] settle_cnt;
  logic in_run;
  logic wr_ok;

  // Straps are sampled only after the synchronisers have filled.
  always_comb begin
    case (state)
      CVTCFG_SETTLE: begin
        next_state = (settle_cnt == `CVTCFG_SETTLE_CYCLES) ?
                     CVTCFG_LOAD : CVTCFG_SETTLE;
      end
      CVTCFG_LOAD: next_state = CVTCFG_RUN;
      CVTCFG_RUN: next_state = CVTCFG_RUN;
      default: next_state = CVTCFG_SETTLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= CVTCFG_SETTLE;
      settle_cnt <= 3'h0;
    end else begin
      state <= next_state;
      if (state == CVTCFG_SETTLE) begin
        settle_cnt <= settle_cnt + 3'h1;
      end
    end
  end

  assign in_run = (state == CVTCFG_RUN);
  assign wr_ok = in_run && wr_en;

  // ****************************************
  // Pin-strap override register
  // ****************************************
  // Power-on reset discards any earlier writes; the strap copy follows.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      external_tracking_select <= 1'b0;
      external_ramp_select <= 1'b0;
      force_skip_during_softstart <= `CVTCFG_FSKIP_RESET;
      soft_start_time_code <= 2'h0;
      undervoltage_latch_select <= 1'b0;
      conduction_mode_select <= 1'b0;
    end else if (state == CVTCFG_LOAD) begin
      external_tracking_select <= pin_f[0];
      external_ramp_select <= pin_f[1];
      soft_start_time_code <= pin_f[3:2];
      undervoltage_latch_select <= pin_f[4];
      conduction_mode_select <= pin_f[5];
    end else if (wr_ok && cmd_code == `CVTCFG_CMD_OVERRIDE) begin
      // Bit 5 is not stored, so it cannot be written.
      external_tracking_select <= wr_data[`CVTCFG_TRK_BIT];
      external_ramp_select <= wr_data[`CVTCFG_SEQ_BIT];
      force_skip_during_softstart <= wr_data[`CVTCFG_FSKIP_BIT];
      soft_start_time_code <=
        wr_data[`CVTCFG_SST_MSB:`CVTCFG_SST_LSB];
      undervoltage_latch_select <= wr_data[`CVTCFG_UVL_BIT];
      conduction_mode_select <= wr_data[`CVTCFG_CM_BIT];
    end
  end

  // ****************************************
  // Loop and frequency register
  // ****************************************
  // Frequency codes run 315 kHz up to 1.225 MHz; the code is passed on.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ramp_injection_enable <= 1'b0;
      ramp_resistor_scale <= 2'h0;
      switching_frequency_code <= `CVTCFG_FS_RESET;
    end else if (state == CVTCFG_LOAD) begin
      ramp_injection_enable <= pin_f[6];
      ramp_resistor_scale <= pin_f[8:7];
    end else if (wr_ok && cmd_code == `CVTCFG_CMD_LOOP) begin
      ramp_injection_enable <= wr_data[`CVTCFG_RINJ_BIT];
      ramp_resistor_scale <= wr_data[`CVTCFG_RRS_MSB:`CVTCFG_RRS_LSB];
      switching_frequency_code <=
        wr_data[`CVTCFG_FS_MSB:`CVTCFG_FS_LSB];
    end
  end

  // ****************************************
  // Delay register
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      power_good_delay_code <= `CVTCFG_PGD_RESET;
      power_on_delay_code <= `CVTCFG_POD_RESET;
    end else if (wr_ok && cmd_code == `CVTCFG_CMD_DELAY) begin
      power_good_delay_code <=
        wr_data[`CVTCFG_PGD_MSB:`CVTCFG_PGD_LSB];
      power_on_delay_code <= wr_data[`CVTCFG_POD_MSB:`CVTCFG_POD_LSB];
    end
  end

  // ****************************************
  // Read-back and answers
  // ****************************************
  logic [7:0] next_rd_data;
  logic mapped;

  // Unused bits are built in as zero rather than stored.
  always_comb begin
    mapped = 1'b1;
    next_rd_data = 8'h00;
    case (cmd_code)
      `CVTCFG_CMD_DELAY: begin
        next_rd_data = {2'h0, power_good_delay_code, power_on_delay_code};
      end
      `CVTCFG_CMD_OVERRIDE: begin
        next_rd_data = {external_tracking_select, external_ramp_select,
                        1'b0, force_skip_during_softstart,
                        soft_start_time_code, undervoltage_latch_select,
                        conduction_mode_select};
      end
      `CVTCFG_CMD_LOOP: begin
        next_rd_data = {ramp_injection_enable, 1'b0, ramp_resistor_scale,
                        1'b0, switching_frequency_code};
      end
      default: mapped = 1'b0;
    endcase
  end

  // Writes before the strap load are refused so straps cannot clobber
  // them; reads of mapped codes are always served.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= 8'h00;
      rd_ack <= 1'b0;
      cmd_nack <= 1'b0;
    end else begin
      rd_ack <= rd_en && mapped;
      if (rd_en && mapped) begin
        rd_data <= next_rd_data;
      end
      cmd_nack <= ((rd_en || wr_en) && !mapped) || (wr_en && !in_run);
    end
  end

  // ****************************************
  // Conduction mode and sequencing
  // ****************************************
  logic us_tick;
  logic [15:0] tick_cnt;

  // Skip mode is forced only while soft start runs and forcing is on.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      forced_continuous_conduction <= 1'b0;
      config_ready <= 1'b0;
    end else begin
      forced_continuous_conduction <= conduction_mode_select &&
        !(force_skip_during_softstart && pin_f[9]);
      config_ready <= in_run;
    end
  end

  // Microsecond time base shared by both delay timers.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_cnt <= 16'h0000;
      us_tick <= 1'b0;
    end else begin
      us_tick <= (tick_cnt == 16'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 16'(TICK_CYCLES - 1)) ?
                  16'h0000 : tick_cnt + 16'h0001;
    end
  end

  cvtcfg_delay_timer #(.LONG_TOP(1'b0)) u_pod (
    .ref_clk(ref_clk),
    .reset(reset),
    .us_tick(us_tick),
    .arm(in_run && pin_f[10]),
    .code(power_on_delay_code),
    .done(power_on_delay_done)
  );

  cvtcfg_delay_timer #(.LONG_TOP(1'b1)) u_pgd (
    .ref_clk(ref_clk),
    .reset(reset),
    .us_tick(us_tick),
    .arm(in_run && pin_f[11]),
    .code(power_good_delay_code),
    .done(power_good_output)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_wr_override;
    in_run && wr_en && cmd_code == `CVTCFG_CMD_OVERRIDE;
  endsequence
  sequence s_rd_cmd(logic [7:0] c);
    rd_en && cmd_code == c;
  endsequence

  property p_freq_reset;
    $fell(reset) |-> switching_frequency_code == 3'h3;
  endproperty
  a_freq_reset: assert property (p_freq_reset)
    else $error("frequency code not 011 after reset");
  property p_pod_reset;
    $fell(reset) |-> power_on_delay_code == 3'h2;
  endproperty
  a_pod_reset: assert property (p_pod_reset)
    else $error("power-on delay code not 010 after reset");
  property p_strap_load;
    state == CVTCFG_LOAD |=> external_tracking_select == $past(pin_f[0])
      && ramp_resistor_scale == $past(pin_f[8:7]);
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("strap value not loaded");
  property p_override_write;
    s_wr_override |=> external_tracking_select == $past(wr_data[7])
      && external_ramp_select == $past(wr_data[6])
      && conduction_mode_select == $past(wr_data[0]);
  endproperty
  a_override_write: assert property (p_override_write)
    else $error("override write not stored");
  property p_override_zero;
    s_rd_cmd(`CVTCFG_CMD_OVERRIDE) |=> rd_ack && !rd_data[5];
  endproperty
  a_override_zero: assert property (p_override_zero)
    else $error("override unused bit not zero");
  property p_loop_zero;
    s_rd_cmd(`CVTCFG_CMD_LOOP) |=> rd_ack && !rd_data[6] && !rd_data[3];
  endproperty
  a_loop_zero: assert property (p_loop_zero)
    else $error("loop unused bits not zero");
  property p_skip_forced;
    force_skip_during_softstart && pin_f[9] |=>
      !forced_continuous_conduction;
  endproperty
  a_skip_forced: assert property (p_skip_forced)
    else $error("continuous mode during forced skip");
  property p_mode_follow;
    !force_skip_during_softstart |=>
      forced_continuous_conduction == $past(conduction_mode_select);
  endproperty
  a_mode_follow: assert property (p_mode_follow)
    else $error("conduction mode not followed");
  property p_early_write;
    wr_en && !in_run |=> cmd_nack;
  endproperty
  a_early_write: assert property (p_early_write)
    else $error("write before strap load not refused");
endmodule

`default_nettype wire

// File: sim/cvtcfg_board_model.sv
`timescale 1ns/100ps
`default_nettype none

module cvtcfg_board_model (
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic reset,
  // Strap setting chosen by the bench
  input wire logic [8:0] strap_set,
  // Strap pins
  output logic strap_tracking,
  output logic strap_ramp,
  output logic [1:0] strap_soft_start,
  output logic strap_uv_latch,
  output logic strap_conduction,
  output logic strap_ramp_injection,
  output logic [1:0] strap_ramp_resistor
);
  logic [8:0] held;

  // ****************************************
  // Strap resistors
  // ****************************************
  // Straps are resistors on the board, so they only change while the part
  // sits in power-on reset and stay put long after the release.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      held <= strap_set;
    end
  end

  // The pins follow a new setting at once during reset only.
  assign {strap_tracking, strap_ramp, strap_soft_start, strap_uv_latch,
    strap_conduction, strap_ramp_injection, strap_ramp_resistor} =
    reset ? strap_set : held;
endmodule

`default_nettype wire

// File: sim/test_converter_config_override_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "cvtcfg_defs.svh"

module test_converter_config_override_regs;
  import cvtcfg_pkg::*;
  // ****************************************
  // Stimulus and wiring
  // ****************************************
  localparam logic [8:0] SA = 9'h155;
  localparam logic [8:0] SB = 9'h0AA;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] cmd_code = 8'h00;
  logic wr_en = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic rd_en = 1'b0;
  logic [8:0] strap_set = SA;
  logic softstart_active = 1'b0;
  logic power_on_request = 1'b0;
  logic power_good_request = 1'b0;
  logic [7:0] rd_data;
  logic rd_ack, cmd_nack, strap_tracking, strap_ramp, strap_uv_latch;
  logic strap_conduction, strap_ramp_injection;
  logic [1:0] strap_soft_start, strap_ramp_resistor;
  logic external_tracking_select, external_ramp_select;
  logic force_skip_during_softstart, undervoltage_latch_select;
  logic conduction_mode_select, forced_continuous_conduction;
  logic ramp_injection_enable, config_ready;
  logic power_on_delay_done, power_good_output;
  logic [1:0] soft_start_time_code, ramp_resistor_scale;
  cvtcfg_code3_t switching_frequency_code;
  cvtcfg_code3_t power_good_delay_code, power_on_delay_code;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] v;
  logic nk;
  int f, t0;

  // The half period of 2.5 ns gives 200 MHz.
  always #2.5 ref_clk = ~ref_clk;

  // Cycle count used to time the delay outputs.
  always @(posedge ref_clk) cyc <= cyc + 1;

  // A tick of two cycles keeps the delay checks short.
  cvtcfg_override_regs #(.TICK_CYCLES(2)) u_dut (.ref_clk, .reset,
    .cmd_code, .wr_en, .wr_data, .rd_en, .rd_data, .rd_ack, .cmd_nack,
    .strap_tracking, .strap_ramp, .strap_soft_start, .strap_uv_latch,
    .strap_conduction, .strap_ramp_injection, .strap_ramp_resistor,
    .softstart_active, .power_on_request, .power_good_request,
    .external_tracking_select, .external_ramp_select,
    .force_skip_during_softstart, .soft_start_time_code,
    .undervoltage_latch_select, .conduction_mode_select,
    .forced_continuous_conduction, .ramp_injection_enable,
    .ramp_resistor_scale, .switching_frequency_code,
    .power_good_delay_code, .power_on_delay_code, .config_ready,
    .power_on_delay_done, .power_good_output);

  cvtcfg_board_model u_board (.ref_clk, .reset, .strap_set,
    .strap_tracking, .strap_ramp, .strap_soft_start, .strap_uv_latch,
    .strap_conduction, .strap_ramp_injection, .strap_ramp_resistor);

  // ****************************************
  // Checking and access tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Register images expected from a strap setting.
  function automatic logic [7:0] exp_d2(input logic [8:0] s);
    return {s[8], s[7], 1'b0, 1'b1, s[6:5], s[4], s[3]};
  endfunction
  function automatic logic [7:0] exp_d3(input logic [8:0] s);
    return {s[2], 1'b0, s[1:0], 1'b0, 3'h3};
  endfunction
  function automatic logic [15:0] exp_pins(input logic [8:0] s);
    return {3'h0, s[8:7], 1'b1, s[6:0], 3'h3};
  endfunction
  function automatic logic [15:0] pins();
    return {3'h0, external_tracking_select, external_ramp_select,
      force_skip_during_softstart, soft_start_time_code,
      undervoltage_latch_select, conduction_mode_select,
      ramp_injection_enable, ramp_resistor_scale, switching_frequency_code};
  endfunction

  // Strobes last one cycle; a missing acknowledge returns EE.
  task automatic reg_rd(input logic [7:0] c, output logic [7:0] d,
                        output logic n);
    int i;
    cmd_code = c;
    rd_en = 1'b1;
    @(negedge ref_clk);
    rd_en = 1'b0;
    for (i = 0; i < 3; i++) begin
      if (rd_ack === 1'b1 || cmd_nack === 1'b1) break;
      @(negedge ref_clk);
    end
    d = (rd_ack === 1'b1) ? rd_data : 8'hEE;
    n = cmd_nack;
    // Let one edge pass so a following read does not re-raise the strobe.
    @(negedge ref_clk);
  endtask

  task automatic reg_wr(input logic [7:0] c, input logic [7:0] d,
                        output logic n);
    int i;
    cmd_code = c;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge ref_clk);
    wr_en = 1'b0;
    n = 1'b0;
    for (i = 0; i < 2; i++) begin
      if (cmd_nack === 1'b1) n = 1'b1;
      @(negedge ref_clk);
    end
  endtask

  task automatic wait_until(input int t);
    while (cyc < t) @(negedge ref_clk);
  endtask

  // An early write must be refused while the straps are still loading.
  task automatic do_reset(input logic [8:0] s);
    int i;
    logic n;
    strap_set = s;
    reset = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk({force_skip_during_softstart, switching_frequency_code,
      power_on_delay_code, config_ready}, 16'h00B4);
    reset = 1'b0;
    reg_wr(`CVTCFG_CMD_OVERRIDE, 8'hFF, n);
    chk(n, 1'b1);
    for (i = 0; i < 20 && config_ready !== 1'b1; i++) @(negedge ref_clk);
    chk(pins(), exp_pins(s));
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    do_reset(SA);
    reg_rd(`CVTCFG_CMD_OVERRIDE, v, nk);
    chk(v, exp_d2(SA));
    reg_rd(`CVTCFG_CMD_LOOP, v, nk);
    chk(v, exp_d3(SA));
    reg_rd(`CVTCFG_CMD_DELAY, v, nk);
    chk(v, 8'h02);
    reg_wr(`CVTCFG_CMD_OVERRIDE, 8'hFF, nk);
    reg_wr(`CVTCFG_CMD_LOOP, 8'hFF, nk);
    reg_wr(`CVTCFG_CMD_DELAY, 8'hFF, nk);
    chk(pins(), 16'h1FFF);
    chk({power_good_delay_code, power_on_delay_code}, 16'h3F);
    reg_rd(`CVTCFG_CMD_OVERRIDE, v, nk);
    chk(v, 8'hDF);
    reg_rd(`CVTCFG_CMD_LOOP, v, nk);
    chk(v, 8'hB7);
    reg_rd(`CVTCFG_CMD_DELAY, v, nk);
    chk(v, 8'h3F);
    // Every frequency code goes through the register and out.
    for (f = 0; f < 8; f++) begin
      reg_wr(`CVTCFG_CMD_LOOP, 8'(f), nk);
      reg_rd(`CVTCFG_CMD_LOOP, v, nk);
      chk({v, 5'h00, switching_frequency_code}, {8'(f), 8'(f)});
    end
    reg_rd(8'hD0, v, nk);
    chk(nk, 1'b1);
    reg_wr(8'hD4, 8'h00, nk);
    chk(nk, 1'b1);
    // Forced skip only matters while the soft start runs.
    reg_wr(`CVTCFG_CMD_OVERRIDE, 8'h11, nk);
    repeat (8) @(negedge ref_clk);
    chk(forced_continuous_conduction, 1'b1);
    softstart_active = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(forced_continuous_conduction, 1'b0);
    reg_wr(`CVTCFG_CMD_OVERRIDE, 8'h01, nk);
    chk(forced_continuous_conduction, 1'b1);
    softstart_active = 1'b0;
    // Good delay code 1 is 1024 cycles, on delay code 0 is 512 cycles.
    reg_wr(`CVTCFG_CMD_DELAY, 8'h08, nk);
    power_on_request = 1'b1;
    power_good_request = 1'b1;
    t0 = cyc;
    wait_until(t0 + 500);
    chk(power_on_delay_done, 1'b0);
    wait_until(t0 + 540);
    chk(power_on_delay_done, 1'b1);
    wait_until(t0 + 1012);
    chk(power_good_output, 1'b0);
    wait_until(t0 + 1052);
    chk(power_good_output, 1'b1);
    power_on_request = 1'b0;
    power_good_request = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk({power_on_delay_done, power_good_output}, 16'h0);
    // A second power-on reset drops every write for the new straps.
    do_reset(SB);
    reg_rd(`CVTCFG_CMD_OVERRIDE, v, nk);
    chk(v, exp_d2(SB));
    reg_rd(`CVTCFG_CMD_LOOP, v, nk);
    chk(v, exp_d3(SB));
    reg_rd(`CVTCFG_CMD_DELAY, v, nk);
    chk(v, 8'h02);
    tally_and_finish();
  end

  // The run needs about 1200 cycles, so 60000 means a hang.
  initial begin
    #300000;
    n_fail++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule

`default_nettype wire
